/* File: logic/jdp_top.sv */
// Debug test access port, debug port registers and MCU identification.
// Assumes tck_i from the debugger, clk_i free running, ap side on clk_i.
`include "jdp_cfg.svh"
`default_nettype none

module jdp_top
  import jdp_pkg::*;
#(
  parameter logic [15:0] REVISION_FIELD = 16'h0001, // Arbitrary value
  parameter logic [11:0] DEVICE_FIELD = 12'h001, // Arbitrary value
  parameter logic [31:0] CORE_IDCODE = 32'h1000_0001, // Arbitrary value
  parameter logic [31:0] BSCAN_IDCODE = 32'h2000_0001, // Arbitrary value
  parameter logic [31:0] JEDEC_WORD = 32'h0000_0001 // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic ap_req_o,
  output jdp_ap_req_t ap_req_data_o,
  input wire logic ap_done_i,
  input wire logic [31:0] ap_rdata_i,
  input wire logic ap_err_i,
  output logic abort_o,
  output logic sys_pwrup_req_o,
  output logic dbg_pwrup_req_o,
  input wire logic sys_pwrup_ack_i,
  input wire logic dbg_pwrup_ack_i,
  input wire logic mcu_rd_i,
  input wire logic [31:0] mcu_addr_i,
  input wire logic mcu_full_word_i,
  output logic mcu_ack_o,
  output logic mcu_err_o,
  output logic [31:0] mcu_rdata_o,
  output logic [31:0] bscan_idcode_o
);
  localparam logic [3:0] OFS_CTRL = `JDP_OFS_CTRL;
  localparam logic [3:0] OFS_SELECT = `JDP_OFS_SELECT;
  localparam logic [3:0] OFS_POSTED_READ_BUFFER = `JDP_OFS_POSTED_READ_BUFFER;

  // Elaboration checks: codes must be distinct and carry the marker bit
  if (CORE_IDCODE == BSCAN_IDCODE) begin : g_chk_id
    $error("core and boundary scan codes must differ");
  end
  if (CORE_IDCODE[0] != 1'b1 || BSCAN_IDCODE[0] != 1'b1) begin : g_chk_lsb
    $error("identification codes need bit 0 set");
  end

  // Boundary scan port code, fixed
  assign bscan_idcode_o = BSCAN_IDCODE;

  // Reset release on each clock; trst only ever loads constants
  logic rst_ff1_q, rst_n_q, trst_ff1_q, trst_n_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_ff1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_ff1_q <= 1'b1;
      rst_n_q <= rst_ff1_q;
    end
  end
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      trst_ff1_q <= 1'b0;
      trst_n_q <= 1'b0;
    end else begin
      trst_ff1_q <= 1'b1;
      trst_n_q <= trst_ff1_q;
    end
  end

  // Controller next state from the mode select line
  function automatic jdp_tap_t tap_next(input jdp_tap_t s, input logic m);
    case (s)
      JDP_TLR: tap_next = m ? JDP_TLR : JDP_RTI;
      JDP_RTI: tap_next = m ? JDP_SELDR : JDP_RTI;
      JDP_SELDR: tap_next = m ? JDP_SELIR : JDP_CAPDR;
      JDP_CAPDR: tap_next = m ? JDP_EX1DR : JDP_SHDR;
      JDP_SHDR: tap_next = m ? JDP_EX1DR : JDP_SHDR;
      JDP_EX1DR: tap_next = m ? JDP_UPDR : JDP_PADR;
      JDP_PADR: tap_next = m ? JDP_EX2DR : JDP_PADR;
      JDP_EX2DR: tap_next = m ? JDP_UPDR : JDP_SHDR;
      JDP_UPDR: tap_next = m ? JDP_SELDR : JDP_RTI;
      JDP_SELIR: tap_next = m ? JDP_TLR : JDP_CAPIR;
      JDP_CAPIR: tap_next = m ? JDP_EX1IR : JDP_SHIR;
      JDP_SHIR: tap_next = m ? JDP_EX1IR : JDP_SHIR;
      JDP_EX1IR: tap_next = m ? JDP_UPIR : JDP_PAIR;
      JDP_PAIR: tap_next = m ? JDP_EX2IR : JDP_PAIR;
      JDP_EX2IR: tap_next = m ? JDP_UPIR : JDP_SHIR;
      JDP_UPIR: tap_next = m ? JDP_SELDR : JDP_RTI;
      default: tap_next = JDP_TLR;
    endcase
  endfunction

  // Link side state
  jdp_tap_t tap_q, tap_d;
  logic [3:0] ir_q, ir_sh_q, ir_sh_d;
  logic [34:0] dr_sh_q, dr_sh_d;
  jdp_acc_t req_q;
  logic req_tgl_q, abt_tgl_q, done_ff1_q, done_s_q;
  logic tdo_q, tdo_oe_q;
  // System side state
  logic rq1_q, rq2_q, rq3_q, ab1_q, ab2_q, ab3_q, done_tgl_q;
  logic [31:0] rdata_q, posted_read_buffer_q, sel_q;
  logic ap_pend_q, readok_q, sticky_q, sys_req_q, dbg_req_q;

  // Instruction decode; unlisted codes fall to bypass
  wire sel_id = (ir_q == `JDP_IR_IDCODE);
  wire sel_dp = (ir_q == `JDP_IR_PORT_ACCESS_CHAIN);
  wire sel_ap = (ir_q == `JDP_IR_ACCESS_PORT_CHAIN);
  wire sel_abort = (ir_q == `JDP_IR_ABORT);
  wire sel_acc = sel_dp | sel_ap;
  wire sel_35 = sel_acc | sel_abort;
  wire link_busy = req_tgl_q ^ done_s_q;
  wire [2:0] cap_ack = link_busy ? `JDP_ACK_WAIT : `JDP_ACK_OK;
  // Read data is stable whenever no request is outstanding
  wire [31:0] cap_data = link_busy ? 32'h0 : rdata_q;

  // Data chain: capture, shift into the top of the selected length
  always_comb begin
    dr_sh_d = dr_sh_q;
    if (tap_q == JDP_CAPDR) begin
      if (sel_acc) dr_sh_d = {cap_data, cap_ack};
      else if (sel_id) dr_sh_d = {3'h0, CORE_IDCODE};
      else dr_sh_d = 35'h0;
    end else if (tap_q == JDP_SHDR) begin
      if (sel_35) dr_sh_d = {tdi_i, dr_sh_q[34:1]};
      else if (sel_id) dr_sh_d = {3'h0, tdi_i, dr_sh_q[31:1]};
      else dr_sh_d = {34'h0, tdi_i};
    end
  end

  // Instruction chain
  always_comb begin
    ir_sh_d = ir_sh_q;
    if (tap_q == JDP_CAPIR) ir_sh_d = `JDP_IR_CAPTURE;
    else if (tap_q == JDP_SHIR) ir_sh_d = {tdi_i, ir_sh_q[3:1]};
  end

  assign tap_d = tap_next(tap_q, tms_i);

  // Controller and chains; instruction resets as reset state is entered
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      tap_q <= JDP_TLR;
      ir_q <= `JDP_IR_RESET;
      ir_sh_q <= 4'h0;
      dr_sh_q <= 35'h0;
    end else if (!trst_n_q) begin
      tap_q <= JDP_TLR;
      ir_q <= `JDP_IR_RESET;
    end else begin
      tap_q <= tap_d;
      ir_sh_q <= ir_sh_d;
      dr_sh_q <= dr_sh_d;
      if (tap_d == JDP_TLR) ir_q <= `JDP_IR_RESET;
      else if (tap_q == JDP_UPIR) ir_q <= ir_sh_q;
    end
  end

  // Update starts an access unless one is still outstanding
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      req_q <= '0;
      req_tgl_q <= 1'b0;
      abt_tgl_q <= 1'b0;
    end else if (tap_q == JDP_UPDR) begin
      if (sel_acc && !link_busy) begin
        req_q <= {dr_sh_q[34:3], dr_sh_q[2:1], dr_sh_q[0], sel_ap};
        req_tgl_q <= ~req_tgl_q;
      end
      if (sel_abort && dr_sh_q[0]) abt_tgl_q <= ~abt_tgl_q;
    end
  end

  // Completion toggle back into the link domain
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      done_ff1_q <= 1'b0;
      done_s_q <= 1'b0;
    end else begin
      done_ff1_q <= done_tgl_q;
      done_s_q <= done_ff1_q;
    end
  end

  // Output changes on the falling edge, as the host samples on rising
  always_ff @(negedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q <= (tap_q == JDP_SHIR) ? ir_sh_q[0] : dr_sh_q[0];
      tdo_oe_q <= (tap_q == JDP_SHIR) || (tap_q == JDP_SHDR);
    end
  end
  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdo_oe_q;

  // Request and abort toggles into the system clock
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      {rq1_q, rq2_q, rq3_q} <= 3'h0;
      {ab1_q, ab2_q, ab3_q} <= 3'h0;
    end else begin
      {rq1_q, rq2_q, rq3_q} <= {req_tgl_q, rq1_q, rq2_q};
      {ab1_q, ab2_q, ab3_q} <= {abt_tgl_q, ab1_q, ab2_q};
    end
  end
  wire req_new = rq2_q ^ rq3_q;
  wire abt_new = ab2_q ^ ab3_q;
  wire dp_new = req_new && !req_q.is_ap;
  wire ap_new = req_new && req_q.is_ap;
  wire dp_wr = dp_new && !req_q.read_not_write;
  wire dp_rd = dp_new && req_q.read_not_write;
  wire ap_fin = ap_pend_q && ap_done_i;
  wire wr_ctrl = dp_wr && (req_q.addr == OFS_CTRL[3:2]);
  wire wr_sel = dp_wr && (req_q.addr == OFS_SELECT[3:2]);

  // Control/status image; acknowledges mirror the power controller
  wire [31:0] ctrl_word = ({31'h0, sys_pwrup_ack_i} << `JDP_CTRL_SYS_ACK)
    | ({31'h0, sys_req_q} << `JDP_CTRL_SYS_REQ)
    | ({31'h0, dbg_pwrup_ack_i} << `JDP_CTRL_DBG_ACK)
    | ({31'h0, dbg_req_q} << `JDP_CTRL_DBG_REQ)
    | ({31'h0, readok_q} << `JDP_CTRL_READOK)
    | ({31'h0, sticky_q} << `JDP_CTRL_STICKY);
  // Only the port and bank fields of select are writable
  wire [31:0] sel_mask = ({32{1'b1}} << `JDP_SEL_PORT_LO)
    | ({28'h0, 4'hf} << `JDP_SEL_BANK_LO);
  wire [31:0] dp_rd_word =
    (req_q.addr == OFS_CTRL[3:2]) ? ctrl_word :
    (req_q.addr == OFS_SELECT[3:2]) ? sel_q :
    (req_q.addr == OFS_POSTED_READ_BUFFER[3:2]) ? posted_read_buffer_q :
    `JDP_RESET_WORD;

  // Debug port registers: select and the power-up requests
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sel_q <= `JDP_RESET_WORD;
      sys_req_q <= 1'b0;
      dbg_req_q <= 1'b0;
    end else begin
      if (wr_sel) sel_q <= req_q.data & sel_mask;
      if (wr_ctrl) begin
        sys_req_q <= req_q.data[`JDP_CTRL_SYS_REQ];
        dbg_req_q <= req_q.data[`JDP_CTRL_DBG_REQ];
      end
    end
  end

  // Status flags; a fault arriving with an abort still sets sticky
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      readok_q <= 1'b0;
      sticky_q <= 1'b0;
    end else begin
      if (abt_new) sticky_q <= 1'b0;
      if (ap_fin && ap_err_i) sticky_q <= 1'b1;
      if (ap_fin && ap_req_data_o.read_not_write) readok_q <= !ap_err_i;
    end
  end

  // Access port request, result capture and completion toggle
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ap_pend_q <= 1'b0;
      ap_req_o <= 1'b0;
      ap_req_data_o <= '0;
      rdata_q <= `JDP_RESET_WORD;
      posted_read_buffer_q <= `JDP_RESET_WORD;
      done_tgl_q <= 1'b0;
      abort_o <= 1'b0;
    end else begin
      ap_req_o <= ap_new;
      abort_o <= abt_new;
      if (ap_new) begin
        ap_req_data_o <= {sel_q[`JDP_SEL_PORT_HI:`JDP_SEL_PORT_LO],
          sel_q[`JDP_SEL_BANK_HI:`JDP_SEL_BANK_LO], req_q.addr,
          req_q.read_not_write, req_q.data};
        ap_pend_q <= 1'b1;
      end else if (ap_fin || (abt_new && ap_pend_q)) begin
        ap_pend_q <= 1'b0;
        done_tgl_q <= ~done_tgl_q;
        if (ap_fin && ap_req_data_o.read_not_write) begin
          rdata_q <= ap_rdata_i; // Posted: seen on the next capture
          posted_read_buffer_q <= ap_rdata_i;
        end
      end else if (dp_new) begin
        if (dp_rd) rdata_q <= dp_rd_word;
        done_tgl_q <= ~done_tgl_q;
      end
    end
  end
  assign sys_pwrup_req_o = sys_req_q;
  assign dbg_pwrup_req_o = dbg_req_q;

  // Identification read answers are registered and cleared by system reset
  wire mcu_hit = (mcu_addr_i == `JDP_MCU_ID_ADDR);
  wire rom_hit = (mcu_addr_i[31:`JDP_ROM_AW] == `JDP_ROM_BASE >> `JDP_ROM_AW);
  wire jedec_hit = rom_hit && (mcu_addr_i[11:0] == `JDP_ROM_JEDEC_OFS);
  wire [31:0] mcu_word = {REVISION_FIELD, 4'h0, DEVICE_FIELD};
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mcu_ack_o <= 1'b0;
      mcu_err_o <= 1'b0;
      mcu_rdata_o <= `JDP_RESET_WORD;
    end else begin
      mcu_ack_o <= mcu_rd_i;
      mcu_err_o <= mcu_rd_i && (!mcu_full_word_i || !(mcu_hit || rom_hit));
      if (mcu_rd_i) begin
        mcu_rdata_o <= !mcu_full_word_i ? 32'h0 :
          mcu_hit ? mcu_word : jedec_hit ? JEDEC_WORD : 32'h0;
      end
    end
  end

  // Checks on the system clock
  a_ap_one_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    ap_req_o |=> !ap_req_o) else $error("ap request longer than a cycle");
  a_ap_target_sel: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    ap_new |=> ap_req_data_o.port_select_field == $past(sel_q[31:24])
    && ap_req_data_o.addr == $past(req_q.addr))
    else $error("ap target not from select");
  a_sel_reserved: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    sel_q[23:8] == 16'h0 && sel_q[3:0] == 4'h0)
    else $error("select reserved bits set");
  a_sel_write: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    wr_sel |=> sel_q[31:24] == $past(req_q.data[31:24]))
    else $error("select write lost");
  a_posted_read_buffer_posted: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    dp_rd && req_q.addr == 2'h3 && !ap_pend_q
    |=> rdata_q == $past(posted_read_buffer_q) && !ap_req_o && !ap_pend_q)
    else $error("read buffer started an access");
  a_mcu_fields: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    mcu_rd_i && mcu_full_word_i && mcu_hit
    |=> mcu_rdata_o == {REVISION_FIELD, 4'h0, DEVICE_FIELD} && !mcu_err_o)
    else $error("identification word wrong");
  a_mcu_narrow: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    mcu_rd_i && !mcu_full_word_i |=> mcu_err_o && mcu_rdata_o == 32'h0)
    else $error("narrow access not refused");
  a_abort_follows: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    abt_new && ap_pend_q |=> abort_o && !ap_pend_q)
    else $error("abort did not end access");
  a_pwr_request: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    wr_ctrl |=> sys_pwrup_req_o == $past(req_q.data[30]))
    else $error("power request not taken");
  // Checks on the link clock
  a_tap_reset: assert property (@(posedge tck_i) disable iff (!trst_n_q)
    tms_i [*5] |=> tap_q == JDP_TLR && ir_q == 4'he)
    else $error("five ones did not reset");
  a_bypass_zero: assert property (@(posedge tck_i) disable iff (!trst_n_q)
    tap_q == JDP_CAPDR && !sel_id && !sel_35 |=> dr_sh_q == 35'h0)
    else $error("bypass capture not zero");
  a_ack_wait: assert property (@(posedge tck_i) disable iff (!trst_n_q)
    tap_q == JDP_CAPDR && sel_acc && link_busy |=> dr_sh_q[2:0] == 3'h1)
    else $error("busy chain not answering wait");
  a_id_capture: assert property (@(posedge tck_i) disable iff (!trst_n_q)
    tap_q == JDP_CAPDR && sel_id |=> dr_sh_q[31:0] == CORE_IDCODE)
    else $error("core code not captured");

  c_ap_read: cover property (@(posedge clk_i) disable iff (!rst_n_q)
    ap_fin && ap_req_data_o.read_not_write);
  c_abort: cover property (@(posedge clk_i) disable iff (!rst_n_q) abort_o);
  c_mcu_read: cover property (@(posedge clk_i) disable iff (!rst_n_q)
    mcu_ack_o && !mcu_err_o);
  c_wait: cover property (@(posedge tck_i) disable iff (!trst_n_q)
    tap_q == JDP_CAPDR && sel_acc && link_busy);
endmodule
`default_nettype wire

/* File: logic/jdp_cfg.svh */
// Constants of the debug port: instruction codes, offsets, field spots.
// Assumes inclusion by bare name from the top module and the testbench.
`ifndef JDP_CFG_SVH
`define JDP_CFG_SVH
`define JDP_IR_RESET 4'he
`define JDP_IR_BYPASS 4'hf
`define JDP_IR_IDCODE 4'he
`define JDP_IR_PORT_ACCESS_CHAIN 4'ha
`define JDP_IR_ACCESS_PORT_CHAIN 4'hb
`define JDP_IR_ABORT 4'h8
`define JDP_IR_CAPTURE 4'h1
`define JDP_ACK_OK 3'h2
`define JDP_ACK_WAIT 3'h1
`define JDP_OFS_RSVD 4'h0
`define JDP_OFS_CTRL 4'h4
`define JDP_OFS_SELECT 4'h8
`define JDP_OFS_POSTED_READ_BUFFER 4'hc
`define JDP_SEL_PORT_HI 31
`define JDP_SEL_PORT_LO 24
`define JDP_SEL_BANK_HI 7
`define JDP_SEL_BANK_LO 4
`define JDP_CTRL_SYS_ACK 31
`define JDP_CTRL_SYS_REQ 30
`define JDP_CTRL_DBG_ACK 29
`define JDP_CTRL_DBG_REQ 28
`define JDP_CTRL_READOK 6
`define JDP_CTRL_STICKY 5
`define JDP_RESET_WORD 32'h0000_0000
`define JDP_MCU_ID_ADDR 32'he004_2000
`define JDP_ROM_BASE 32'he00f_f000
`define JDP_ROM_AW 12
`define JDP_ROM_JEDEC_OFS 12'h000
`endif

/* File: logic/jdp_pkg.sv */
// Types shared by the debug port: controller states and carried words.
// Assumes the constants header sits beside it.
`default_nettype none
package jdp_pkg;
  // Controller states of the test access port
  typedef enum logic [3:0] {
    JDP_TLR, JDP_RTI, JDP_SELDR, JDP_CAPDR, JDP_SHDR, JDP_EX1DR,
    JDP_PADR, JDP_EX2DR, JDP_UPDR, JDP_SELIR, JDP_CAPIR, JDP_SHIR,
    JDP_EX1IR, JDP_PAIR, JDP_EX2IR, JDP_UPIR
  } jdp_tap_t;

  // Access shifted in on an access chain
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] addr;
    logic read_not_write;
    logic is_ap;
  } jdp_acc_t;

  // Request handed to the access port
  typedef struct packed {
    logic [7:0] port_select_field;
    logic [3:0] bank_window_field;
    logic [1:0] addr;
    logic read_not_write;
    logic [31:0] wdata;
  } jdp_ap_req_t;
endpackage
`default_nettype wire

/* File: bench/jdp_host.sv */
// Debugger host model: walks the test port controller and shifts chains.
// Assumes the port samples on tck rising and moves tdo on tck falling.
`default_nettype none
module jdp_host (
  output logic tck_o,
  output logic trst_n_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_oe;
  logic oe_ok;

  // Pull-up levels on tms and tdi, test reset asserted; clock parked low, it only runs in frames
  initial begin
    tck_o = 1'b0;
    trst_n_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    oe_ok = 1'b1;
    last_oe = 1'b0;
  end

  // One 64 ns tck period; tdo and its enable taken at the rising edge
  task automatic tick(input logic m, input logic d, output logic o);
    tms_o = m;
    tdi_o = d;
    #32 tck_o = 1'b1;
    o = tdo_i;
    last_oe = tdo_oe_i;
    #32 tck_o = 1'b0;
  endtask

  // Leave test reset, force test-logic-reset by ones, then idle
  task automatic tap_reset();
    logic x;
    #100 trst_n_o = 1'b1;
    repeat (8) tick(1'b1, 1'b1, x);
    tick(1'b0, 1'b1, x);
  endtask

  // Scan of n bits, least significant first, from and back to idle
  task automatic scan(input logic ir, input int n, input logic [34:0] din,
                      output logic [34:0] dout);
    logic x;
    logic o;
    tick(1'b1, 1'b1, x);
    if (ir) begin
      tick(1'b1, 1'b1, x);
    end
    tick(1'b0, 1'b1, x);
    tick(1'b0, 1'b1, x);
    dout = '0;
    oe_ok = 1'b1;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
      oe_ok = oe_ok & last_oe;
    end
    tick(1'b1, 1'b1, x);
    tick(1'b0, 1'b1, x);
  endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Testbench of the debug port: host model on the link, stand-ins elsewhere.
// Assumes the constants header and package compiled before this file.
`include "jdp_cfg.svh"
`default_nettype none
module tb
  import jdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] REV = 16'h00a1; // Arbitrary value
  localparam logic [11:0] DEV = 12'h0b2; // Arbitrary value
  localparam logic [31:0] CORE_ID = 32'h1234_5671; // Arbitrary value
  localparam logic [31:0] BSCAN_ID = 32'h7654_3211; // Arbitrary value
  localparam logic [31:0] JEDEC = 32'h0000_0abc; // Arbitrary value
  localparam logic [31:0] AP_DATA = 32'hc3c3_1234;
  logic clk_i, arst_n_i, tck, trst_n, tms, tdi, tdo, tdo_oe;
  logic ap_req, ap_done, abort, sys_req, dbg_req, sys_ack, dbg_ack;
  logic mcu_rd, mcu_full, mcu_ack, mcu_err;
  logic [31:0] ap_rdata, mcu_addr, mcu_rdata, bscan_id;
  jdp_ap_req_t ap_data;
  int err_total, checks, n_req, n_abort, ap_wait, pend;

  jdp_host u_host (.tck_o(tck), .trst_n_o(trst_n), .tms_o(tms),
    .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

  jdp_top #(.REVISION_FIELD(REV), .DEVICE_FIELD(DEV), .CORE_IDCODE(CORE_ID),
    .BSCAN_IDCODE(BSCAN_ID), .JEDEC_WORD(JEDEC)) u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .tck_i(tck), .trst_n_i(trst_n),
    .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .ap_req_o(ap_req), .ap_req_data_o(ap_data), .ap_done_i(ap_done),
    .ap_rdata_i(ap_rdata), .ap_err_i(1'b0), .abort_o(abort),
    .sys_pwrup_req_o(sys_req), .dbg_pwrup_req_o(dbg_req),
    .sys_pwrup_ack_i(sys_ack), .dbg_pwrup_ack_i(dbg_ack),
    .mcu_rd_i(mcu_rd), .mcu_addr_i(mcu_addr), .mcu_full_word_i(mcu_full),
    .mcu_ack_o(mcu_ack), .mcu_err_o(mcu_err), .mcu_rdata_o(mcu_rdata),
    .bscan_idcode_o(bscan_id));

  // Read data is garbage outside the done cycle, so stale values fail
  assign ap_rdata = ap_done ? AP_DATA : ~AP_DATA;

  // Access port and power stand-ins; an abort drops the pending access
  always @(posedge clk_i) begin
    #2;
    ap_done = 1'b0;
    sys_ack = sys_req;
    dbg_ack = dbg_req;
    if (abort) begin
      pend = 0;
      n_abort++;
    end
    if (ap_req) begin
      n_req++;
      pend = ap_wait;
    end else if (pend == 1) begin
      ap_done = 1'b1;
      pend = 0;
    end else if (pend > 1) begin
      pend--;
    end
  end

  task automatic report_and_stop();
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_v(input string nm, input logic [46:0] e,
                       input logic [46:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Room for the update to cross and finish before the next capture
  task automatic settle();
    #1500;
  endtask

  task automatic ir(input logic [3:0] c);
    logic [34:0] d;
    u_host.scan(1'b1, 4, {31'h0, c}, d);
    cmp_v("ir_capture", 47'h1, 47'(d[3:0]));
  endtask

  task automatic dr(input int n, input logic [34:0] di,
                    output logic [34:0] dq);
    u_host.scan(1'b0, n, di, dq);
    cmp_v("tdo_enable", 47'h1, 47'(u_host.oe_ok));
  endtask

  task automatic mcu(input logic [31:0] a, input logic f,
                     input logic [31:0] ed, input logic ee);
    @(posedge clk_i);
    #2;
    mcu_rd = 1'b1;
    mcu_addr = a;
    mcu_full = f;
    @(posedge clk_i);
    #2;
    mcu_rd = 1'b0;
    cmp_v("mcu_answer", 47'({1'b1, ee, ed}),
          47'({mcu_ack, mcu_err, mcu_rdata}));
  endtask

  task automatic t_mcu();
    mcu(32'he004_2000, 1'b1, {REV, 4'h0, DEV}, 1'b0);
    cmp_v("device_field", 47'(DEV), 47'(mcu_rdata[11:0]));
    mcu(32'he004_2000, 1'b0, 32'h0, 1'b1);
    mcu(32'he00f_f000, 1'b1, JEDEC, 1'b0);
    mcu(32'he00f_f004, 1'b1, 32'h0, 1'b0);
    mcu(32'he004_2004, 1'b1, 32'h0, 1'b1);
    cmp_v("bscan_id", 47'(BSCAN_ID), 47'(bscan_id));
  endtask

  task automatic t_id();
    logic [34:0] q;
    dr(32, 35'h0, q);
    cmp_v("id_after_reset", 47'(CORE_ID), 47'(q[31:0]));
    ir(`JDP_IR_IDCODE);
    dr(32, 35'h0, q);
    cmp_v("id_code", 47'(CORE_ID), 47'(q[31:0]));
  endtask

  // Bypass adds one zero ahead of the shifted pattern
  task automatic t_byp();
    logic [34:0] q;
    logic [3:0] codes [3];
    codes = '{`JDP_IR_BYPASS, 4'h3, 4'h0};
    foreach (codes[i]) begin
      ir(codes[i]);
      dr(8, 35'h5b, q);
      cmp_v("bypass", 47'hb6, 47'(q[7:0]));
    end
  endtask

  task automatic t_dp();
    logic [34:0] q;
    ir(`JDP_IR_PORT_ACCESS_CHAIN);
    dr(35, {32'h5a00_0030, 2'b10, 1'b0}, q);
    settle();
    dr(35, {32'h5000_0000, 2'b01, 1'b0}, q);
    settle();
    cmp_v("pwrup_reqs", 47'h3, 47'({sys_req, dbg_req}));
    dr(35, {32'h0, 2'b10, 1'b1}, q);
    cmp_v("ack_ok", 47'h2, 47'(q[2:0]));
    settle();
    dr(35, {32'h0, 2'b01, 1'b1}, q);
    cmp_v("select_read", 47'h5a00_0030, 47'(q[34:3]));
    settle();
    dr(35, {32'h0, 2'b00, 1'b1}, q);
    cmp_v("ctrl_read", 47'hf, 47'(q[34:31]));
    settle();
    dr(35, {32'h0, 2'b00, 1'b1}, q);
    cmp_v("reserved_read", 47'h0, 47'(q[34:3]));
  endtask

  task automatic t_ap();
    logic [34:0] q;
    n_req = 0;
    ap_wait = 3;
    ir(`JDP_IR_ACCESS_PORT_CHAIN);
    dr(35, {32'hdead_0001, 2'b01, 1'b0}, q);
    settle();
    cmp_v("ap_request", 47'({8'h5a, 4'h3, 2'b01, 1'b0, 32'hdead_0001}),
          47'(ap_data));
    dr(35, {32'h0, 2'b11, 1'b1}, q);
    settle();
    ir(`JDP_IR_PORT_ACCESS_CHAIN);
    dr(35, {32'h0, 2'b11, 1'b1}, q);
    settle();
    dr(35, {32'h0, 2'b11, 1'b1}, q);
    cmp_v("posted_read", 47'(AP_DATA), 47'(q[34:3]));
    cmp_v("ap_requests", 47'd2, 47'(n_req));
    ap_wait = 80;
    ir(`JDP_IR_ACCESS_PORT_CHAIN);
    dr(35, {32'h0, 2'b00, 1'b1}, q);
    settle();
    dr(35, {32'h0, 2'b00, 1'b1}, q);
    cmp_v("ack_wait", 47'h1, 47'(q[2:0]));
    #10000;
    cmp_v("dropped_update", 47'd3, 47'(n_req));
  endtask

  // Abort with bit 0 clear does nothing; set, it frees a stuck access
  task automatic t_abort();
    logic [34:0] q;
    n_abort = 0;
    ap_wait = 300; // Outlasts the task, so only the abort can end it
    dr(35, {32'h0, 2'b00, 1'b1}, q);
    ir(`JDP_IR_ABORT);
    dr(35, 35'h0, q);
    settle();
    cmp_v("abort_clear", 47'd0, 47'(n_abort));
    dr(35, 35'h1, q);
    settle();
    cmp_v("abort_set", 47'd1, 47'(n_abort));
    ir(`JDP_IR_ACCESS_PORT_CHAIN);
    dr(35, {32'h0, 2'b00, 1'b1}, q);
    cmp_v("ack_after_abort", 47'h2, 47'(q[2:0]));
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Span well above the expected run of about 84 us
  initial begin
    #2000000;
    err_total++;
    report_and_stop();
  end

  initial begin
    arst_n_i = 1'b0;
    ap_done = 1'b0;
    sys_ack = 1'b0;
    dbg_ack = 1'b0;
    mcu_rd = 1'b0;
    mcu_addr = 32'h0;
    mcu_full = 1'b1;
    err_total = 0;
    checks = 0;
    n_req = 0;
    n_abort = 0;
    ap_wait = 3;
    pend = 0;
    repeat (12) @(posedge clk_i);
    #2 arst_n_i = 1'b1;
    repeat (5) @(posedge clk_i);
    u_host.tap_reset();
    t_mcu();
    t_id();
    t_byp();
    t_dp();
    t_ap();
    t_abort();
    report_and_stop();
  end
endmodule
`default_nettype wire
